// ==== core/spsc_top.sv ====
/*
  Register write protection lock and standby (halt) controller.
  Assumes CPU writes, the halt strobe and interrupt requests are
  synchronous to clk_sys; the interrupt controller presents its highest
  pending level and keeps level-mode external requests asserted.
*/
`timescale 1ns/1ps
// What this block does
// R01 - Non-key value written to key locks
// R02 - Writing key 1F unlocks guarded registers
// R03 - Lock flag readable; reset clears lock
// R04 - Key register stays writable while locked
// R05 - Halt selects depth from two-bit selector
// R06 - CPU sleep: enabled peripherals keep running
// R07 - Oscillator sleep: clock stops, peripherals halt
// R08 - Full stop halts everything including oscillator
// R09 - Ports hold state in lighter sleeps
// R10 - Level at or above mask wakes, serviced
// R11 - Masked ordinary request keeps device halted
// R12 - Non-maskable request always wakes and serviced
// R13 - External 0-4 wake unserviced, flag kept
// R14 - Reset reinitialises settings; interrupt wake keeps
// R15 - Reset source allows 3 ms warm-up; srst here returns straight to run with no warm-up count
// R16 - Full stop exit waits selected warm-up
// R17 - Interrupt wake from stop after warm-up
// R18 - Wake sampled while halted, restart synchronous
// R19 - Stop pin drive follows drive-select bit
// R20 - Level external wake held until serviced
// R21 - Locked writes complete silently, no change
module spsc_top #(
  parameter int WARMUP_8  = spsc_pkg::WARMUP_CNT_8,
  parameter int WARMUP_14 = spsc_pkg::WARMUP_CNT_14,
  parameter int WARMUP_16 = spsc_pkg::WARMUP_CNT_16
) (
  input  wire logic                      clk_sys,          // System clock, 40 MHz
  input  wire logic                      srst,             // Synchronous reset, high
  input  wire spsc_pkg::spsc_wr_t        cpu_wr,           // CPU register write
  input  wire logic                      halt_exec,        // Halt instruction pulse
  input  wire logic [2:0]                irq_mask,         // CPU interrupt mask
  input  wire logic                      irq_req,          // Maskable request pending
  input  wire logic [2:0]                irq_level,        // Its priority level
  input  wire logic                      nmi_req,          // Non-maskable request
  input  wire logic [4:0]                ext_wake,         // External inputs 0..4
  input  wire spsc_pkg::spsc_run_t       run_en,           // Sleep-run enables
  output logic                           protect_on,       // Lock flag
  output logic [7:0]                     noise_control_reg, // Readback with lock
  output logic [7:0]                     sys_config_reg_a, // Guarded config A
  output logic [7:0]                     sys_config_reg_b, // Guarded config B
  output logic [7:0]                     cswait_cfg,       // Guarded CS/wait data
  output spsc_pkg::spsc_standby_t        standby_cfg,      // Standby config
  output logic                           cpu_stall,        // CPU execution halted
  output logic                           sys_clk_en,       // System clock enable
  output logic                           osc_en,           // Oscillator enable
  output spsc_pkg::spsc_run_t            periph_run,       // Per-peripheral run
  output logic                           irq_ctrl_run,     // Interrupt ctrl active
  output logic                           port_hold,        // I/O ports frozen
  output logic                           pin_float,        // Stop: float pins
  output logic                           osc_out_high,     // Oscillator out pin high
  output logic                           wake_service,     // Resume with service
  output logic                           wake_resume       // Resume without service
);

  // Warm-up length for a selector value
  function automatic logic [spsc_pkg::WARMUP_W-1:0] warm_len(input logic [1:0] s);
    case (s)
      spsc_pkg::WARMUP_SEL_8:  warm_len = spsc_pkg::WARMUP_W'(WARMUP_8);
      spsc_pkg::WARMUP_SEL_14: warm_len = spsc_pkg::WARMUP_W'(WARMUP_14);
      spsc_pkg::WARMUP_SEL_16: warm_len = spsc_pkg::WARMUP_W'(WARMUP_16);
      default:                 warm_len = spsc_pkg::WARMUP_W'(WARMUP_8);
    endcase
  endfunction

  spsc_pkg::spsc_state_t         state_q;
  logic [spsc_pkg::WARMUP_W-1:0] warm_q;
  logic                          svc_q;
  logic                          lock_q;
  logic [7:0]                    noise_q;
  spsc_pkg::spsc_standby_t       stby_q;
  logic                          wr_ok;
  logic                          wake_en;
  logic                          wake_ext;
  logic                          wake_any;

  // Guarded writes pass only when unlocked; key always writable
  assign wr_ok = cpu_wr.wr && !lock_q; // R21

  // Lock state, cleared by reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lock_q <= 1'b0; // R03
    end else if (cpu_wr.wr && cpu_wr.sel == spsc_pkg::SPSC_SEL_KEY) begin // R04
      lock_q <= (cpu_wr.data != spsc_pkg::PROTECT_KEY_OPEN); // R01 R02
    end
  end

  // Guarded clock-gear and chip-select registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      noise_q          <= spsc_pkg::NOISE_CTRL_RST; // R14
      sys_config_reg_a <= spsc_pkg::CFG_RST;
      sys_config_reg_b <= spsc_pkg::CFG_RST;
      cswait_cfg       <= spsc_pkg::CFG_RST;
      stby_q           <= '0;
    end else if (wr_ok) begin // R04 R21
      case (cpu_wr.sel)
        spsc_pkg::SPSC_SEL_NOISE:   noise_q <= cpu_wr.data;
        spsc_pkg::SPSC_SEL_CFG_A:   sys_config_reg_a <= cpu_wr.data;
        spsc_pkg::SPSC_SEL_CFG_B:   sys_config_reg_b <= cpu_wr.data;
        spsc_pkg::SPSC_SEL_CSWAIT:  cswait_cfg <= cpu_wr.data;
        spsc_pkg::SPSC_SEL_STANDBY: stby_q <= cpu_wr.data[4:0];
        default:                    noise_q <= noise_q;
      endcase
    end
  end

  // Lock flag merged into the noise-control readback
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      protect_on        <= 1'b0;
      noise_control_reg <= spsc_pkg::NOISE_CTRL_RST;
      standby_cfg       <= '0;
    end else begin
      protect_on        <= lock_q; // R03
      noise_control_reg <= noise_q;
      noise_control_reg[spsc_pkg::NOISE_LOCK_BIT] <= lock_q; // R03
      standby_cfg       <= stby_q;
    end
  end

  // Wake qualification: enabled level, NMI, or external 0-4
  assign wake_en  = nmi_req || (irq_req && irq_level >= irq_mask); // R10 R11 R12
  assign wake_ext = |ext_wake; // R13 R20
  assign wake_any = wake_en || wake_ext; // R18

  // Halt state machine
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= spsc_pkg::SPSC_RUN; // R14
      warm_q  <= '0;
      svc_q   <= 1'b0;
    end else begin
      case (state_q)
        spsc_pkg::SPSC_RUN: begin
          if (halt_exec) begin
            case (stby_q.sleep_depth_select) // R05
              spsc_pkg::DEPTH_CPU_ONLY:  state_q <= spsc_pkg::SPSC_CPU_SLEEP;
              spsc_pkg::DEPTH_OSC_ONLY:  state_q <= spsc_pkg::SPSC_OSC_SLEEP;
              spsc_pkg::DEPTH_FULL_STOP: state_q <= spsc_pkg::SPSC_STOP;
              default:                   state_q <= spsc_pkg::SPSC_RUN;
            endcase
          end
        end
        spsc_pkg::SPSC_CPU_SLEEP, spsc_pkg::SPSC_OSC_SLEEP: begin
          if (wake_any) begin // R18
            svc_q   <= wake_en;
            state_q <= spsc_pkg::SPSC_RESUME;
          end
        end
        spsc_pkg::SPSC_STOP: begin
          if (wake_any) begin
            svc_q   <= wake_en;
            warm_q  <= warm_len(stby_q.warmup_count_select); // R16
            state_q <= spsc_pkg::SPSC_WARMUP;
          end
        end
        spsc_pkg::SPSC_WARMUP: begin
          if (warm_q <= spsc_pkg::WARMUP_W'(1)) begin
            state_q <= spsc_pkg::SPSC_RESUME; // R17
          end else begin
            warm_q <= warm_q - spsc_pkg::WARMUP_W'(1); // R16
          end
        end
        spsc_pkg::SPSC_RESUME: state_q <= spsc_pkg::SPSC_RUN;
        default:               state_q <= spsc_pkg::SPSC_RUN;
      endcase
    end
  end

  // Per-mode controls, registered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cpu_stall    <= 1'b0;
      sys_clk_en   <= 1'b1;
      osc_en       <= 1'b1;
      periph_run   <= '1;
      irq_ctrl_run <= 1'b1;
      port_hold    <= 1'b0;
      pin_float    <= 1'b0;
      osc_out_high <= 1'b0;
      wake_service <= 1'b0;
      wake_resume  <= 1'b0;
    end else begin
      cpu_stall    <= state_q != spsc_pkg::SPSC_RUN && state_q != spsc_pkg::SPSC_RESUME;
      sys_clk_en   <= state_q == spsc_pkg::SPSC_RUN || state_q == spsc_pkg::SPSC_RESUME
                      || state_q == spsc_pkg::SPSC_CPU_SLEEP; // R07 R16
      osc_en       <= state_q != spsc_pkg::SPSC_STOP; // R08
      irq_ctrl_run <= state_q == spsc_pkg::SPSC_RUN || state_q == spsc_pkg::SPSC_RESUME
                      || state_q == spsc_pkg::SPSC_CPU_SLEEP; // R06
      periph_run   <= (state_q == spsc_pkg::SPSC_CPU_SLEEP) ? run_en // R06
                      : (state_q == spsc_pkg::SPSC_RUN || state_q == spsc_pkg::SPSC_RESUME)
                      ? '1 : '0; // R07 R08
      port_hold    <= state_q == spsc_pkg::SPSC_CPU_SLEEP
                      || state_q == spsc_pkg::SPSC_OSC_SLEEP; // R09
      pin_float    <= state_q == spsc_pkg::SPSC_STOP && !stby_q.stop_pin_drive; // R19
      osc_out_high <= state_q == spsc_pkg::SPSC_STOP; // R19
      wake_service <= state_q == spsc_pkg::SPSC_RESUME && svc_q; // R10 R12
      wake_resume  <= state_q == spsc_pkg::SPSC_RESUME && !svc_q; // R13
    end
  end

endmodule

// ==== pkg/spsc_pkg.sv ====
/*
  Shared constants and carrier types for the register protection and
  standby controller. Assumes a single 40 MHz system clock domain.
*/
package spsc_pkg;

  // Protection key that releases the lock
  localparam logic [7:0] PROTECT_KEY_OPEN = 8'h1f;

  // Sleep depth selector encodings
  localparam logic [1:0] DEPTH_CPU_ONLY = 2'h3;
  localparam logic [1:0] DEPTH_OSC_ONLY = 2'h2;
  localparam logic [1:0] DEPTH_FULL_STOP = 2'h1;

  // Warm-up count selector encodings
  localparam logic [1:0] WARMUP_SEL_8  = 2'h1;
  localparam logic [1:0] WARMUP_SEL_14 = 2'h2;
  localparam logic [1:0] WARMUP_SEL_16 = 2'h3;

  // Warm-up counts in oscillator periods
  localparam int WARMUP_CNT_8  = 256;
  localparam int WARMUP_CNT_14 = 16384;
  localparam int WARMUP_CNT_16 = 65536;
  localparam int WARMUP_W      = 17;

  // Reset values, NMI level, lock bit position and external wake input count
  localparam logic [7:0] NOISE_CTRL_RST = 8'h23;
  localparam logic [7:0] CFG_RST        = 8'h00;
  localparam logic [2:0] MASK_RST       = 3'h7;
  localparam logic [2:0] NMI_LEVEL      = 3'h7;
  localparam int         NOISE_LOCK_BIT = 7;
  localparam int         EXT_WAKE_N     = 5;

  // Register selector for key and guarded writes
  typedef enum logic [2:0] {
    SPSC_SEL_KEY,
    SPSC_SEL_NOISE,
    SPSC_SEL_CFG_A,
    SPSC_SEL_CFG_B,
    SPSC_SEL_STANDBY,
    SPSC_SEL_CSWAIT
  } spsc_sel_t;

  // CPU write request
  typedef struct packed {
    logic       wr;
    spsc_sel_t  sel;
    logic [7:0] data;
  } spsc_wr_t;

  // Standby configuration fields
  typedef struct packed {
    logic [1:0] sleep_depth_select;
    logic [1:0] warmup_count_select;
    logic       stop_pin_drive;
  } spsc_standby_t;

  // Peripheral sleep-run enables
  typedef struct packed {
    logic timer01_sleep_run;
    logic serial0_sleep_run;
    logic converter_sleep_run;
    logic watchdog_sleep_run;
  } spsc_run_t;

  // Standby controller states
  typedef enum logic [2:0] {
    SPSC_RUN,
    SPSC_CPU_SLEEP,
    SPSC_OSC_SLEEP,
    SPSC_STOP,
    SPSC_WARMUP,
    SPSC_RESUME
  } spsc_state_t;

endpackage

// ==== tb/spsc_irq_model.sv ====
/* Interrupt side model: raises wake requests on command.
   Requests are held until the block pulses a wake. */
`timescale 1ns/1ps
module spsc_irq_model (
  input  wire logic       clk_sys,   // Clock
  input  wire logic       srst,      // Reset
  input  wire logic [1:0] cmd,       // 1 irq, 2 ext, 3 nmi
  input  wire logic [2:0] lvl,       // Irq level
  input  wire logic       done,      // Wake pulse
  output logic            irq_req,   // Maskable request
  output logic [2:0]      irq_level, // Its level
  output logic            nmi_req,   // Non-maskable
  output logic [4:0]      ext_wake   // External flags
);
  // Hold requests until the wake is seen; idle level keeps changing
  always_ff @(posedge clk_sys) begin
    if (srst || done) begin
      irq_req <= 1'b0;
      nmi_req <= 1'b0;
      ext_wake <= 5'h00;
      irq_level <= 3'h0;
    end else begin
      if (cmd == 2'h1) irq_req <= 1'b1;
      if (cmd == 2'h1) irq_level <= lvl;
      else if (!irq_req) irq_level <= ~irq_level;
      if (cmd == 2'h2) ext_wake <= 5'h10;
      if (cmd == 2'h3) nmi_req <= 1'b1;
    end
  end
endmodule

// ==== tb/spsc_props.sv ====
/* Port checks for spsc_top.
   Bound to each spsc_top; reads its ports only. */
`timescale 1ns/1ps
module spsc_props (
  input wire logic                    clk_sys,          // Clock
  input wire logic                    srst,             // Reset
  input wire spsc_pkg::spsc_wr_t      cpu_wr,           // Write
  input wire logic                    halt_exec,        // Halt
  input wire logic [2:0]              irq_mask,         // Mask
  input wire logic                    irq_req,          // Request
  input wire logic [2:0]              irq_level,        // Level
  input wire logic                    nmi_req,          // NMI
  input wire logic [4:0]              ext_wake,         // External
  input wire logic                    protect_on,       // Lock
  input wire logic [7:0]              sys_config_reg_a, // Config A
  input wire spsc_pkg::spsc_standby_t standby_cfg,      // Standby
  input wire logic                    cpu_stall,        // Stall
  input wire logic                    port_hold,        // Hold
  input wire logic                    wake_service,     // Service
  input wire logic                    wake_resume       // Resume
);
  logic hi;
  logic kw;
  // Enabled maskable request and key write
  assign hi = irq_req && irq_level >= irq_mask;
  assign kw = cpu_wr.wr && cpu_wr.sel == spsc_pkg::SPSC_SEL_KEY;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Light sleep with no wake cause
  sequence s_quiet;
    port_hold && !nmi_req && ext_wake == 5'h00 && !hi;
  endsequence
  a_key_locks: assert property (kw && cpu_wr.data != 8'h1f |-> ##2 protect_on)
    else $error("lock not set");
  a_key_opens: assert property (kw && cpu_wr.data == 8'h1f |-> ##2 !protect_on)
    else $error("lock not cleared");
  a_cfg_guarded: assert property (cpu_wr.wr && cpu_wr.sel == spsc_pkg::SPSC_SEL_CFG_A
    ##1 protect_on |-> $stable(sys_config_reg_a)) else $error("locked write landed");
  a_halt_sleeps: assert property (!cpu_stall && !$past(halt_exec) && halt_exec
    ##1 standby_cfg.sleep_depth_select != 2'h0 |-> ##1 cpu_stall) else $error("no halt");
  a_irq_wakes: assert property (port_hold && hi |-> ##[1:2] wake_service)
    else $error("irq wake missing");
  a_nmi_wakes: assert property (port_hold && nmi_req |-> ##[1:2] wake_service)
    else $error("nmi wake missing");
  a_ext_resumes: assert property (port_hold && ext_wake != 5'h00 && !nmi_req && !hi
    |-> ##[1:2] wake_resume) else $error("ext wake missing");
  a_masked_holds: assert property (s_quiet [*3] |=> cpu_stall)
    else $error("woke without cause");
endmodule
bind spsc_top spsc_props i_props (.*);

// ==== tb/testbench.sv ====
/* Bench for spsc_top: lock, halt depths, wake paths, reset.
   Uses spsc_irq_model as the interrupt side. */
`timescale 1ns/1ps
module testbench;
  logic clk_sys, srst, halt_exec, irq_req, nmi_req, protect_on, cpu_stall, sys_clk_en;
  logic osc_en, irq_ctrl_run, port_hold, pin_float, osc_out_high, wake_service, wake_resume;
  logic [1:0] cmd, d;
  logic [2:0] irq_mask, irq_level, lvl;
  logic [4:0] ext_wake;
  logic [7:0] noise_control_reg, sys_config_reg_a, sys_config_reg_b, cswait_cfg;
  spsc_pkg::spsc_wr_t      cpu_wr;
  spsc_pkg::spsc_run_t     run_en, periph_run;
  spsc_pkg::spsc_standby_t standby_cfg;
  int mismatches, check_count, cyc, n;
  spsc_top #(.WARMUP_8(4), .WARMUP_14(8), .WARMUP_16(16)) i_spsc_top (.*);
  spsc_irq_model i_spsc_irq_model (.*, .done(wake_service | wake_resume));
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Cycle ceiling against a hang
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic tk(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(string s, logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic wr(logic [2:0] s, logic [7:0] v);
    tk(1);
    cpu_wr <= {1'b1, s, v};
    tk(1);
    cpu_wr.wr <= 1'b0;
  endtask
  task automatic halt();
    tk(1);
    halt_exec <= 1'b1;
    tk(1);
    halt_exec <= 1'b0;
    tk(2);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    srst = 1'b1;
    halt_exec = 1'b0;
    cpu_wr = '0;
    irq_mask = 3'h5;
    cmd = 2'h0;
    lvl = 3'h0;
    run_en = 4'ha;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    tk(1);
    chk("lock", protect_on, 8'h00);
    chk("noise", noise_control_reg, spsc_pkg::NOISE_CTRL_RST);
    wr(3'h2, 8'h5a);
    chk("cfga", sys_config_reg_a, 8'h5a);
    wr(3'h0, 8'h00);
    tk(2);
    chk("noise", noise_control_reg, 8'ha3);
    wr(3'h2, 8'ha5);
    wr(3'h5, 8'h77);
    wr(3'h0, 8'h1e);
    tk(2);
    chk("cfga", sys_config_reg_a, 8'h5a);
    chk("csw", cswait_cfg, 8'h00);
    chk("lock", protect_on, 8'h01);
    wr(3'h0, 8'h1f);
    tk(2);
    chk("lock", protect_on, 8'h00);
    wr(3'h3, 8'h3c);
    chk("cfgb", sys_config_reg_b, 8'h3c);
    for (int i = 3; i > 0; i--) begin
      d = i[1:0];
      wr(3'h4, {3'h0, d, 2'h1, 1'b0});
      lvl <= 3'h2;
      cmd <= 2'h1;
      halt();
      cmd <= 2'h0;
      chk("stall", cpu_stall, 8'h01);
      chk("hold", port_hold, d != 2'h1);
      chk("clk", sys_clk_en, d == 2'h3);
      chk("osc", osc_en, d != 2'h1);
      chk("run", periph_run, d == 2'h3 ? 4'(run_en) : 4'h0);
      chk("float", pin_float, d == 2'h1);
      chk("oscout", osc_out_high, d == 2'h1);
      chk("irqc", irq_ctrl_run, d == 2'h3);
      tk(5);
      chk("stall", cpu_stall, 8'h01);
      lvl <= 3'h5;
      cmd <= d == 2'h3 ? 2'h1 : (d == 2'h2 ? 2'h2 : 2'h3);
      tk(1);
      cmd <= 2'h0;
      n = 0;
      while (!(wake_service || wake_resume) && n < 300) begin
        tk(1);
        n++;
      end
      chk("svc", wake_service, d != 2'h2);
      chk("res", wake_resume, d == 2'h2);
      chk("stall", cpu_stall, 8'h00);
      if (d == 2'h1) chk("warm", n > 4, 8'h01);
    end
    // Non-maskable wake out of CPU-only sleep
    wr(3'h4, 8'h18);
    halt();
    cmd <= 2'h3;
    tk(1);
    cmd <= 2'h0;
    tk(2);
    chk("nmi", wake_service, 8'h01);
    wr(3'h4, 8'h0a);
    wr(3'h0, 8'h00);
    wr(3'h4, 8'h1e);
    tk(1);
    chk("stby", standby_cfg, 8'h0a);
    halt();
    srst <= 1'b1;
    tk(2);
    srst <= 1'b0;
    tk(1);
    chk("stall", cpu_stall, 8'h00);
    chk("lock", protect_on, 8'h00);
    chk("cfgb", sys_config_reg_b, 8'h00);
    report_and_stop();
  end
endmodule
